/* core/asog_cfg.svh */
// register offsets, field positions and reset values of the setup/offset/gain bank
`ifndef ASOG_CFG_SVH
`define ASOG_CFG_SVH
`define ASOG_OFS_SYNC      6'h00
`define ASOG_OFS_DIAG      6'h04
`define ASOG_OFS_DAC_R     6'h08
`define ASOG_OFS_DAC_G     6'h0C
`define ASOG_OFS_DAC_B     6'h10
`define ASOG_OFS_DAC_ALL   6'h14
`define ASOG_OFS_GAIN_R    6'h18
`define ASOG_OFS_SEL       6'h1C
`define ASOG_OFS_STATUS    6'h20
`define ASOG_RST_SYNC      8'h00
`define ASOG_RST_DIAG      8'h16
`define ASOG_RST_DAC       8'h80
`define ASOG_RST_GAIN      8'h00
`define ASOG_RST_SEL       2'h0
`define ASOG_BIT_DET_EN    0
`define ASOG_BIT_POL       4
`define ASOG_BIT_INPUT_RESISTANCE_SELECT    0
`define ASOG_BIT_TEST      7
`define ASOG_DLY_LSB       1
`define ASOG_OPD_LSB       3
`define ASOG_COL_RED       2'h0
`define ASOG_COL_GREEN     2'h1
`define ASOG_COL_BLUE      2'h2
`endif

/* core/asog_pkg.sv */
// types of the setup/offset/gain register bank
package asog_pkg;
   typedef struct packed {
      logic       cyc;
      logic       stb;
      logic       we;
      logic [5:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } asog_wb_req_t;
   typedef struct packed {
      logic       sync_pulse;
      logic       video_clk;
      logic       adc_clk;
      logic       reset_clk;
   } asog_timing_t;
   typedef enum logic [1:0] {ASOG_IDLE, ASOG_COUNT} asog_state_t;
endpackage : asog_pkg

/* core/asog_regs.sv */
// setup, test, offset and gain register bank with sync-pulse detector
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "asog_cfg.svh"
module asog_regs
   import asog_pkg::*;
#(
   parameter int DLY_W = 3
) (
   input  wire logic        MCLK,
   input  wire logic        RESET,
   input  wire logic        CE,
   input  wire logic        WB_CYC,
   input  wire logic        WB_STB,
   input  wire logic        WB_WE,
   input  wire logic [5:0]  WB_ADR,
   input  wire logic [3:0]  WB_SEL,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK,
   input  wire logic        SAMPLE_SYNC_INPUT,
   input  wire logic        VIDEO_CLK,
   input  wire logic        ADC_CLK,
   input  wire logic        RESET_CLK,
   input  wire logic [3:0]  CONV_NIBBLE,
   output logic      [3:0]  NIBBLE_OUTPUT,
   output logic             INTERNAL_SYNC_PULSE,
   output logic             INPUT_RESISTANCE_SELECT,
   output logic      [1:0]  OUTPUT_DELAY_SELECT,
   output logic      [7:0]  OFFSET_CODE,
   output logic      [7:0]  GAIN_CODE,
   output logic             GAIN_IS_RED
);
   asog_wb_req_t req;
   logic [7:0]   sync_ff;
   logic [7:0]   diag_ff;
   logic [7:0]   dac_r_ff;
   logic [7:0]   dac_g_ff;
   logic [7:0]   dac_b_ff;
   logic [7:0]   gain_r_ff;
   logic [1:0]   colour_select_ff;
   logic         ack_ff;
   logic [31:0]  rdata_ff;
   logic [31:0]  nxt_rdata;
   logic         wr_en;
   logic         lane0;
   logic [2:0]   ss_ff;
   logic         edge_seen;
   logic [DLY_W-1:0] cnt_ff;
   asog_state_t  state_ff;
   logic         pulse_ff;
   logic [3:0]   tsync1_ff;
   logic [3:0]   tsync2_ff;
   logic [3:0]   nib_ff;
   logic         det_en;
   logic [DLY_W-1:0] detect_delay;

   assign req = '{cyc: WB_CYC, stb: WB_STB, we: WB_WE, adr: WB_ADR, sel: WB_SEL,
                  dat: WB_DAT_I};
   assign lane0 = req.sel[0];
   // ack one cycle after the strobe, dropped the cycle after
   // writes need byte lane 0; the other lanes carry nothing here
   assign wr_en = req.cyc && req.stb && req.we && !ack_ff && lane0 && CE;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         ack_ff <= 1'b0;
      end else if (CE) begin
         ack_ff <= req.cyc && req.stb && !ack_ff;
      end
   end

   // reserved bits stored as written, except colour select which keeps only bits 1:0; software keeps them at fixed values
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         sync_ff          <= `ASOG_RST_SYNC;
         diag_ff          <= `ASOG_RST_DIAG;
         gain_r_ff        <= `ASOG_RST_GAIN;
         colour_select_ff <= `ASOG_RST_SEL;
      end else if (wr_en) begin
         case (req.adr)
            `ASOG_OFS_SYNC:   sync_ff   <= req.dat[7:0];
            `ASOG_OFS_DIAG:   diag_ff   <= req.dat[7:0];
            `ASOG_OFS_GAIN_R: gain_r_ff <= req.dat[7:0];
            `ASOG_OFS_SEL:    colour_select_ff <= req.dat[1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         dac_r_ff <= `ASOG_RST_DAC;
         dac_g_ff <= `ASOG_RST_DAC;
         dac_b_ff <= `ASOG_RST_DAC;
      end else if (wr_en) begin
         case (req.adr)
            `ASOG_OFS_DAC_R: dac_r_ff <= req.dat[7:0];
            `ASOG_OFS_DAC_G: dac_g_ff <= req.dat[7:0];
            `ASOG_OFS_DAC_B: dac_b_ff <= req.dat[7:0];
            `ASOG_OFS_DAC_ALL: begin
               dac_r_ff <= req.dat[7:0];
               dac_g_ff <= req.dat[7:0];
               dac_b_ff <= req.dat[7:0];
            end
            default: ;
         endcase
      end
   end

   always_comb begin
      nxt_rdata = 32'h00000000;
      case (req.adr)
         `ASOG_OFS_SYNC:   nxt_rdata[7:0] = sync_ff;
         `ASOG_OFS_DIAG:   nxt_rdata[7:0] = diag_ff;
         `ASOG_OFS_DAC_R:  nxt_rdata[7:0] = dac_r_ff;
         `ASOG_OFS_DAC_G:  nxt_rdata[7:0] = dac_g_ff;
         `ASOG_OFS_DAC_B:  nxt_rdata[7:0] = dac_b_ff;
         `ASOG_OFS_GAIN_R: nxt_rdata[7:0] = gain_r_ff;
         `ASOG_OFS_SEL:    nxt_rdata[1:0] = colour_select_ff;
         `ASOG_OFS_STATUS: nxt_rdata[1:0] = {state_ff == ASOG_COUNT, pulse_ff};
         default:          nxt_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         rdata_ff <= 32'h00000000;
      end else if (CE && req.cyc && req.stb && !ack_ff) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign WB_ACK   = ack_ff;
   assign WB_DAT_O = rdata_ff;

   assign det_en       = sync_ff[`ASOG_BIT_DET_EN];
   assign detect_delay = sync_ff[`ASOG_DLY_LSB +: DLY_W];

   // pin is asynchronous: two flops, then a third for edge detection
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         ss_ff <= 3'h0;
      end else if (CE) begin
         ss_ff <= {ss_ff[1:0], SAMPLE_SYNC_INPUT};
      end
   end

   assign edge_seen = sync_ff[`ASOG_BIT_POL] ? (ss_ff[1] && !ss_ff[2])
                                              : (!ss_ff[1] && ss_ff[2]);

   // edges during the count are ignored; pulse is one clock wide
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         state_ff <= ASOG_IDLE;
         cnt_ff   <= '0;
         pulse_ff <= 1'b0;
      end else if (CE) begin
         pulse_ff <= 1'b0;
         case (state_ff)
            ASOG_IDLE: begin
               if (det_en && edge_seen) begin
                  if (detect_delay == '0) begin
                     pulse_ff <= 1'b1;
                  end else begin
                     cnt_ff   <= detect_delay;
                     state_ff <= ASOG_COUNT;
                  end
               end
            end
            ASOG_COUNT: begin
               if (!det_en) begin
                  state_ff <= ASOG_IDLE;
               end else if (cnt_ff == DLY_W'(1)) begin
                  pulse_ff <= 1'b1;
                  state_ff <= ASOG_IDLE;
               end else begin
                  cnt_ff <= cnt_ff - DLY_W'(1);
               end
            end
            default: state_ff <= ASOG_IDLE;
         endcase
      end
   end

   // detect off: synchronised input passed straight on
   assign INTERNAL_SYNC_PULSE = det_en ? pulse_ff : ss_ff[1];

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         tsync1_ff <= 4'h0;
         tsync2_ff <= 4'h0;
         nib_ff    <= 4'h0;
      end else if (CE) begin
         tsync1_ff <= {1'b0, VIDEO_CLK, ADC_CLK, RESET_CLK};
         tsync2_ff <= tsync1_ff;
         nib_ff    <= diag_ff[`ASOG_BIT_TEST]
                      ? {INTERNAL_SYNC_PULSE, tsync2_ff[2:0]} : CONV_NIBBLE;
      end
   end
   assign NIBBLE_OUTPUT = nib_ff;

   assign INPUT_RESISTANCE_SELECT = diag_ff[`ASOG_BIT_INPUT_RESISTANCE_SELECT];
   // code 11 not trapped: passes through as written
   assign OUTPUT_DELAY_SELECT = diag_ff[`ASOG_OPD_LSB +: 2];

   // reserved colour code falls back to red rather than a dead output
   always_comb begin
      case (colour_select_ff)
         `ASOG_COL_RED:   OFFSET_CODE = dac_r_ff;
         `ASOG_COL_GREEN: OFFSET_CODE = dac_g_ff;
         `ASOG_COL_BLUE:  OFFSET_CODE = dac_b_ff;
         default:         OFFSET_CODE = dac_r_ff;
      endcase
   end
   // only red gain lives here; other gains belong elsewhere
   assign GAIN_IS_RED = (colour_select_ff == `ASOG_COL_RED);
   assign GAIN_CODE   = gain_r_ff;

   ack_pulse_a: assert property (@(posedge MCLK) disable iff (RESET)
      WB_ACK |=> !WB_ACK)
      else $error("ack held longer than one cycle");
   alias_write_a: assert property (@(posedge MCLK) disable iff (RESET)
      (wr_en && req.adr == `ASOG_OFS_DAC_ALL) |=>
      (dac_r_ff == $past(req.dat[7:0]) && dac_g_ff == dac_r_ff && dac_b_ff == dac_r_ff))
      else $error("alias write did not load all offsets");
   sync_delay_a: assert property (@(posedge MCLK) disable iff (RESET)
      (CE && det_en && state_ff == ASOG_IDLE && edge_seen && detect_delay == DLY_W'(2))
      ##1 (CE && det_en)[*2] |=> pulse_ff)
      else $error("sync pulse not at programmed delay");
   sync_none_a: assert property (@(posedge MCLK) disable iff (RESET)
      (pulse_ff && !$past(pulse_ff)) |-> $past(state_ff == ASOG_COUNT || edge_seen))
      else $error("sync pulse without edge");
   pass_thru_a: assert property (@(posedge MCLK) disable iff (RESET)
      !det_en |-> INTERNAL_SYNC_PULSE == ss_ff[1])
      else $error("input not passed through");
   test_mux_a: assert property (@(posedge MCLK) disable iff (RESET)
      (!RESET && CE && !diag_ff[`ASOG_BIT_TEST]) |=> NIBBLE_OUTPUT == $past(CONV_NIBBLE))
      else $error("nibble pins not carrying data");
   offset_sel_a: assert property (@(posedge MCLK) disable iff (RESET)
      colour_select_ff == `ASOG_COL_BLUE |-> OFFSET_CODE == dac_b_ff)
      else $error("wrong offset selected");
   res_sel_a: assert property (@(posedge MCLK) disable iff (RESET)
      (wr_en && req.adr == `ASOG_OFS_DIAG) |=>
      INPUT_RESISTANCE_SELECT == $past(req.dat[0]) &&
      OUTPUT_DELAY_SELECT == $past(req.dat[4:3]))
      else $error("diagnostic fields not applied");
   gain_wr_a: assert property (@(posedge MCLK) disable iff (RESET)
      (wr_en && req.adr == `ASOG_OFS_GAIN_R) |=> GAIN_CODE == $past(req.dat[7:0]))
      else $error("red gain not stored");

   // bus handshake, read data and clock enable
   ack_resp_a: assert property (@(posedge MCLK) disable iff (RESET)
      (CE && req.cyc && req.stb && !WB_ACK) |=> WB_ACK)
      else $error("request not answered next cycle");
   ack_idle_a: assert property (@(posedge MCLK) disable iff (RESET)
      (CE && !(req.cyc && req.stb)) |=> !WB_ACK)
      else $error("ack without request");
   alias_read_a: assert property (@(posedge MCLK) disable iff (RESET)
      (CE && req.cyc && req.stb && !WB_ACK && req.adr == `ASOG_OFS_DAC_ALL) |=>
      WB_DAT_O == 32'h00000000)
      else $error("alias location did not read zero");
   read_upper_a: assert property (@(posedge MCLK) disable iff (RESET)
      WB_DAT_O[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   freeze_a: assert property (@(posedge MCLK) disable iff (RESET)
      !CE |=> $stable(WB_ACK) && $stable(sync_ff) && $stable(diag_ff) &&
      $stable(dac_r_ff) && $stable(gain_r_ff) && $stable(state_ff) && $stable(nib_ff))
      else $error("state moved with clock enable low");

   // offset, gain and colour registers
   dac_reset_a: assert property (@(posedge MCLK)
      $past(RESET) && !RESET |-> dac_r_ff == `ASOG_RST_DAC && dac_g_ff == `ASOG_RST_DAC &&
      dac_b_ff == `ASOG_RST_DAC && gain_r_ff == `ASOG_RST_GAIN)
      else $error("offset or gain reset value wrong");
   diag_reset_a: assert property (@(posedge MCLK)
      $past(RESET) && !RESET |-> diag_ff == `ASOG_RST_DIAG && sync_ff == `ASOG_RST_SYNC &&
      colour_select_ff == `ASOG_RST_SEL && !WB_ACK)
      else $error("setup reset value wrong");
   dac_green_a: assert property (@(posedge MCLK) disable iff (RESET)
      (wr_en && req.adr == `ASOG_OFS_DAC_G) |=>
      dac_g_ff == $past(req.dat[7:0]) && $stable(dac_r_ff) && $stable(dac_b_ff))
      else $error("green offset write wrong");
   dac_blue_a: assert property (@(posedge MCLK) disable iff (RESET)
      (wr_en && req.adr == `ASOG_OFS_DAC_B) |=> dac_b_ff == $past(req.dat[7:0]))
      else $error("blue offset write wrong");
   offset_red_a: assert property (@(posedge MCLK) disable iff (RESET)
      colour_select_ff == `ASOG_COL_RED |-> OFFSET_CODE == dac_r_ff)
      else $error("red offset not applied");
   offset_green_a: assert property (@(posedge MCLK) disable iff (RESET)
      colour_select_ff == `ASOG_COL_GREEN |-> OFFSET_CODE == dac_g_ff)
      else $error("green offset not applied");
   gain_apply_a: assert property (@(posedge MCLK) disable iff (RESET)
      colour_select_ff == `ASOG_COL_RED |-> GAIN_IS_RED && GAIN_CODE == gain_r_ff)
      else $error("red gain not applied");
   gain_other_a: assert property (@(posedge MCLK) disable iff (RESET)
      colour_select_ff != `ASOG_COL_RED |-> !GAIN_IS_RED)
      else $error("red gain flagged for other colour");
   colour_wr_a: assert property (@(posedge MCLK) disable iff (RESET)
      (wr_en && req.adr == `ASOG_OFS_SEL) |=> colour_select_ff == $past(req.dat[1:0]))
      else $error("colour select not stored");

   // sync detector and test pins
   edge_pulse_a: assert property (@(posedge MCLK) disable iff (RESET)
      (!RESET && CE && det_en && state_ff == ASOG_IDLE && edge_seen && detect_delay == '0)
      |=> pulse_ff)
      else $error("edge with zero delay gave no pulse");
   det_off_a: assert property (@(posedge MCLK) disable iff (RESET)
      (CE && !det_en) |=> !pulse_ff)
      else $error("pulse while detection off");
   count_hold_a: assert property (@(posedge MCLK) disable iff (RESET)
      (!RESET && CE && det_en && state_ff == ASOG_COUNT && cnt_ff != DLY_W'(1)) |=>
      state_ff == ASOG_COUNT && !pulse_ff)
      else $error("delay count ended early");
   test_nib_a: assert property (@(posedge MCLK) disable iff (RESET)
      (!RESET && CE && diag_ff[`ASOG_BIT_TEST]) |=>
      NIBBLE_OUTPUT == {$past(INTERNAL_SYNC_PULSE), $past(tsync2_ff[2:0])})
      else $error("test pins not showing timing signals");

   // main scenarios reached
   alias_c: cover property (@(posedge MCLK) wr_en && req.adr == `ASOG_OFS_DAC_ALL);
   pulse_c: cover property (@(posedge MCLK) det_en && pulse_ff);
   test_c:  cover property (@(posedge MCLK) diag_ff[`ASOG_BIT_TEST] && CE);
   count_c: cover property (@(posedge MCLK) state_ff == ASOG_COUNT && cnt_ff == DLY_W'(1));
   freeze_c: cover property (@(posedge MCLK) !CE && !RESET);
endmodule : asog_regs

/* test/asog_host.sv */
// wishbone classic host model that writes and reads the register bank
`timescale 1ns/1ps
module asog_host
   import asog_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        ack,
   input  wire logic [31:0] rdat,
   output asog_wb_req_t     req
);
   initial req = '0;
   // request held until ack is sampled high; the next call starts one edge later,
   // so cyc and stb stay low for at least one cycle between transfers
   task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      @(posedge clk);
      req <= '{1'b1, 1'b1, w, a, 4'hF, {24'h0, d}};
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat[7:0];
      req <= '0;
   endtask : xfer
endmodule : asog_host

/* test/asog_regs_test.sv */
// self-checking bench of the setup/offset/gain register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module asog_regs_test
   import asog_pkg::*;
;
   typedef struct packed {logic w; logic [5:0] a; logic [7:0] d; logic [7:0] e;} asog_row_t;
   logic         mclk, reset, ssi, vclk, aclk, rclk, ack, isp, inres, gred, ce;
   logic [3:0]   conv, nib;
   logic [1:0]   opd;
   logic [7:0]   ofs, gain, q;
   logic [31:0]  rdat;
   asog_wb_req_t req;
   int           n_errors = 0, n_tests = 0, l0, l1;
   // reset values first, then alias write, gain write and an unmapped place
   asog_row_t    rows [12] = '{
      '{1'b0, 6'h00, 8'h00, 8'h00}, '{1'b0, 6'h04, 8'h00, 8'h16},
      '{1'b0, 6'h08, 8'h00, 8'h80}, '{1'b0, 6'h0C, 8'h00, 8'h80},
      '{1'b0, 6'h10, 8'h00, 8'h80}, '{1'b0, 6'h18, 8'h00, 8'h00},
      '{1'b1, 6'h14, 8'h5A, 8'h00}, '{1'b0, 6'h08, 8'h00, 8'h5A},
      '{1'b0, 6'h0C, 8'h00, 8'h5A}, '{1'b0, 6'h10, 8'h00, 8'h5A},
      '{1'b1, 6'h18, 8'hC3, 8'hC3}, '{1'b1, 6'h3C, 8'hFF, 8'h00}};

   asog_host u_host (.clk(mclk), .ack(ack), .rdat(rdat), .req(req));
   asog_regs #(.DLY_W(3)) u_asog_regs (
      .MCLK(mclk), .RESET(reset), .CE(ce), .WB_CYC(req.cyc), .WB_STB(req.stb),
      .WB_WE(req.we), .WB_ADR(req.adr), .WB_SEL(req.sel), .WB_DAT_I(req.dat),
      .WB_DAT_O(rdat), .WB_ACK(ack), .SAMPLE_SYNC_INPUT(ssi), .VIDEO_CLK(vclk),
      .ADC_CLK(aclk), .RESET_CLK(rclk), .CONV_NIBBLE(conv), .NIBBLE_OUTPUT(nib),
      .INTERNAL_SYNC_PULSE(isp), .INPUT_RESISTANCE_SELECT(inres),
      .OUTPUT_DELAY_SELECT(opd), .OFFSET_CODE(ofs), .GAIN_CODE(gain), .GAIN_IS_RED(gred));

   task automatic finish_test();
      if (n_errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test

   // latency from driving the pin to the first pulse; 20 means none seen
   task automatic lat(input logic v, output int n);
      @(posedge mclk);
      ssi <= v;
      for (n = 1; n < 20; n++) begin
         @(posedge mclk);
         #1;
         if (isp === 1'b1) break;
      end
   endtask : lat

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // whole run is well under a thousand cycles
   initial begin
      repeat (5000) @(posedge mclk);
      n_errors++;
      finish_test();
   end

   initial begin
      reset = 1'b1;
      ce = 1'b1;
      ssi = 1'b0;
      vclk = 1'b1;
      aclk = 1'b0;
      rclk = 1'b1;
      conv = 4'hA;
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].w) u_host.xfer(1'b1, rows[i].a, rows[i].d, q);
         u_host.xfer(1'b0, rows[i].a, 8'h00, q);
         `CHK("readback", rows[i].e, q)
      end
      `CHK("gain", 8'hC3, gain)
      u_host.xfer(1'b1, 6'h0C, 8'h22, q);
      u_host.xfer(1'b1, 6'h10, 8'h33, q);
      for (int c = 0; c < 3; c++) begin
         u_host.xfer(1'b1, 6'h1C, 8'(c), q);
         @(posedge mclk);
         #1;
         `CHK("offset", c == 0 ? 8'h5A : c == 1 ? 8'h22 : 8'h33, ofs)
         `CHK("red", c == 0, gred)
      end
      u_host.xfer(1'b1, 6'h04, 8'h8F, q);
      repeat (5) @(posedge mclk);
      #1;
      `CHK("resistance", 1'b1, inres)
      `CHK("out delay", 2'b01, opd)
      `CHK("test pins", 4'b0101, nib)
      u_host.xfer(1'b1, 6'h04, 8'h16, q);
      repeat (2) @(posedge mclk);
      #1;
      `CHK("data pins", 4'hA, nib)
      u_host.xfer(1'b1, 6'h00, 8'h11, q);
      lat(1'b1, l0);
      `CHK("rising seen", 1'b1, l0 < 20)
      lat(1'b0, l1);
      `CHK("falling ignored", 1'b1, l1 == 20)
      u_host.xfer(1'b1, 6'h00, 8'h15, q);
      lat(1'b1, l1);
      `CHK("delay two", 1'b1, l1 == l0 + 2)
      u_host.xfer(1'b1, 6'h00, 8'h01, q);
      lat(1'b0, l1);
      `CHK("falling edge", 1'b1, l1 == l0)
      u_host.xfer(1'b1, 6'h00, 8'h10, q);
      lat(1'b1, l1);
      `CHK("pass through", 1'b1, l1 < 5)
      @(posedge mclk);
      reset <= 1'b1;
      @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      #1;
      `CHK("offset reset", 8'h80, ofs)
      `CHK("gain reset", 8'h00, gain)
      @(posedge mclk);
      ce <= 1'b0;
      conv <= 4'h3;
      repeat (3) @(posedge mclk);
      #1;
      `CHK("frozen pins", 4'hA, nib)
      @(posedge mclk);
      ce <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      `CHK("resumed pins", 4'h3, nib)
      finish_test();
   end
endmodule : asog_regs_test
